// file: hw/hbs_pkg.sv
// constants, carriers and helpers shared by the serial frame control block
package hbs_pkg;

   // ==========================================================================
   // timing
   localparam int          CLK_MHZ       = 200;
   // fastest serial bit rate the master may use, in kbaud
   localparam int          MAX_BAUD_KBD  = 2000;
   // time the core needs to finish a transfer after the frame ends
   localparam int          PROC_TIME_NS  = 50;
   localparam int          PROC_CYCLES   = (PROC_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam logic [3:0]  PROC_CNT      = 4'(PROC_CYCLES);

   // ==========================================================================
   // frame layout
   localparam logic [5:0]  FRAME_BITS    = 6'h10;
   localparam logic [5:0]  FALL_SAT      = 6'h3F;
   localparam logic [5:0]  ADDR_BITS     = 6'h02;
   localparam logic [4:0]  RISE_SAT      = 5'h1F;
   localparam logic [4:0]  RISE_ADDR     = 5'h02;
   localparam logic [4:0]  RISE_VERIFY   = 5'h07;
   localparam logic [4:0]  RISE_DATA     = 5'h08;
   localparam logic [4:0]  RISE_LAST     = 5'h0F;
   localparam int          ADDR_POS      = 14;
   localparam int          CODE_POS      = 8;
   localparam logic [1:0]  OWN_ADDR      = 2'h0;

   // ==========================================================================
   // instruction codes and fixed replies
   localparam logic [5:0]  CODE_RD_IDENT = 6'h00;
   localparam logic [5:0]  CODE_RD_REV   = 6'h03;
   localparam logic [5:0]  CODE_RD_DIAG  = 6'h09;
   localparam logic [5:0]  CODE_RD_CFG   = 6'h30;
   localparam logic [5:0]  CODE_RD_STAT  = 6'h3C;
   localparam logic [5:0]  CODE_WR_CFG   = 6'h28;
   localparam logic [5:0]  CODE_WR_STAT  = 6'h18;
   localparam logic [4:0]  VERIFY_BITS   = 5'h15;
   localparam logic [7:0]  WRITE_REPLY   = 8'h00;
   localparam logic [7:0]  UNUSED_REPLY  = 8'hFF;

   // ==========================================================================
   // carriers
   typedef struct packed {
      logic [7:0] ident;
      logic [7:0] revision;
      logic [7:0] diag;
      logic [7:0] cfg;
      logic [7:0] statcon;
   } hbs_rd_regs_t;

   typedef enum logic {WR_TGT_CFG, WR_TGT_STAT} hbs_wr_tgt_t;

   typedef struct packed {
      logic        valid;
      hbs_wr_tgt_t target;
      logic [7:0]  data;
   } hbs_wr_t;

   typedef enum logic {CORE_IDLE, CORE_BUSY} hbs_core_st_t;

   typedef struct packed {
      logic         ss_s1;
      logic         ss_s2;
      logic         ss_s3;
      logic         rst_hold;
      hbs_core_st_t st;
      logic [3:0]   proc_cnt;
      logic         overrun;
      logic         err;
      logic         parity;
      hbs_rd_regs_t snap;
      hbs_wr_t      wr;
   } hbs_core_t;

   typedef struct packed {
      logic        tag;
      logic [5:0]  count;
      logic [1:0]  addr;
      logic [15:0] shift;
   } hbs_fall_t;

   typedef struct packed {
      logic [4:0] cnt;
      logic       addr_ok;
      logic       so;
      logic       so_oe;
      logic [7:0] dout;
   } hbs_rise_t;

   typedef struct packed {
      logic tag;
      logic sent;
   } hbs_mark_t;

   // ==========================================================================
   // helpers
   function automatic logic hbs_code_used(input logic [5:0] code);
      hbs_code_used = (code == CODE_RD_IDENT) || (code == CODE_RD_REV) ||
                      (code == CODE_RD_DIAG)  || (code == CODE_RD_CFG) ||
                      (code == CODE_RD_STAT)  || (code == CODE_WR_CFG) ||
                      (code == CODE_WR_STAT);
   endfunction : hbs_code_used

   function automatic logic [7:0] hbs_reply(input logic [5:0]   code,
                                            input hbs_rd_regs_t regs);
      case (code)
         CODE_RD_IDENT: hbs_reply = regs.ident;
         CODE_RD_REV:   hbs_reply = regs.revision;
         CODE_RD_DIAG:  hbs_reply = regs.diag;
         CODE_RD_CFG:   hbs_reply = regs.cfg;
         CODE_RD_STAT:  hbs_reply = regs.statcon;
         CODE_WR_CFG:   hbs_reply = WRITE_REPLY;
         CODE_WR_STAT:  hbs_reply = WRITE_REPLY;
         default:       hbs_reply = UNUSED_REPLY;
      endcase
   endfunction : hbs_reply

endpackage : hbs_pkg

// file: hw/hbs_frame_ctrl.sv
// serial slave frame control: sampling, reply, validity and failure flag
`timescale 1ns/1ps
`default_nettype none

// Operation
// - device is slave, master at most 2 Mbaud
// - output tristate while select is high
// - reset holds idle state, output tristate
// - high select abandons frame, awaits next
// - input sampled on falling clock edges
// - output bit updated on rising edges
// - internal actions start at select rising edge
// - first two input bits carry chip address
// - output tristate until address recognised
// - foreign address: frame ignored, output tristate
// - verification byte sent during instruction byte
// - read frames discard incoming data byte
// - valid write replies with zero data byte
// - unused instruction code makes frame invalid
// - frame during busy processing is invalid
// - falling edge count must equal sixteen
// - unused code replies all-ones in frame
// - invalid frame sets failure flag next frame
// - flag clears only after being shifted out
// - frame is sixteen bits, two bytes each way
// - upper two bits address, zero is ours
// - read data returned in same frame
// - verify byte: two tristate, 10101, flag
module hbs_frame_ctrl (
   input  wire logic                  ref_clk,
   input  wire logic                  resetn,
   input  wire logic                  sck,
   input  wire logic                  ss_n,
   input  wire logic                  si,
   input  wire hbs_pkg::hbs_rd_regs_t rd_regs,
   output logic                       so,
   output logic                       so_oe,
   output hbs_pkg::hbs_wr_t           wr_req,
   output logic                       trans_fail
);
   import hbs_pkg::*;

   // ==========================================================================
   // state
   hbs_core_t  core;
   hbs_core_t  next_core;
   hbs_fall_t  fall;
   hbs_fall_t  next_fall;
   hbs_rise_t  rise;
   hbs_rise_t  next_rise;
   hbs_mark_t  mark;
   hbs_mark_t  next_mark;
   logic       armed;
   logic       link_clr;

   // select high or core reset clears the live link state at once, since
   // the serial clock stands still between frames
   // tristate on deselect
   assign link_clr = ss_n | core.rst_hold;

   // ==========================================================================
   // falling edge side: sampling and edge count
   // armed is the only flag cleared by select; count and shift survive the
   // frame end so the core can read them after select rises
   always_ff @(negedge sck or posedge link_clr) begin
      if (link_clr) begin
         armed <= 1'b0;
      end else begin
         armed <= 1'b1;
      end
   end

   always_comb begin
      next_fall = fall;
      if (!armed) begin
         next_fall.tag   = core.parity;
         next_fall.count = 6'h01;
         next_fall.shift = {15'h0000, si};
      end else begin
         if (fall.count != FALL_SAT) begin
            next_fall.count = fall.count + 6'h01;
         end
         // address kept apart, long frames shift it out
         if (fall.count == ADDR_BITS - 6'h01) begin
            next_fall.addr = {fall.shift[0], si};
         end
         next_fall.shift = {fall.shift[14:0], si};
      end
   end

   always_ff @(negedge sck) begin
      fall <= next_fall;
   end

   // ==========================================================================
   // rising edge side: output shifter
   always_comb begin
      logic [4:0] vidx;
      logic [4:0] didx;
      logic [7:0] vbyte;
      logic [7:0] reply;
      next_rise = rise;
      vidx      = RISE_VERIFY - rise.cnt;
      didx      = RISE_LAST - rise.cnt;
      vbyte     = {2'h0, VERIFY_BITS, core.err};
      reply     = hbs_reply(fall.shift[5:0], core.snap);
      if (rise.cnt != RISE_SAT) begin
         next_rise.cnt = rise.cnt + 5'h01;
      end
      if (rise.cnt < RISE_ADDR) begin
         next_rise.so    = 1'b0;
         next_rise.so_oe = 1'b0;
      end else if (rise.cnt == RISE_ADDR) begin
         next_rise.addr_ok = (fall.shift[1:0] == OWN_ADDR);
         next_rise.so_oe   = (fall.shift[1:0] == OWN_ADDR);
         next_rise.so      = vbyte[vidx[2:0]];
      end else if (rise.cnt < RISE_DATA) begin
         next_rise.so = vbyte[vidx[2:0]];
      end else if (rise.cnt == RISE_DATA) begin
         next_rise.dout = reply;
         next_rise.so   = reply[7];
      end else if (rise.cnt <= RISE_LAST) begin
         next_rise.so = rise.dout[didx[2:0]];
      end else begin
         next_rise.so = 1'b0;
      end
   end

   always_ff @(posedge sck or posedge link_clr) begin
      if (link_clr) begin
         rise <= '0;
      end else begin
         rise <= next_rise;
      end
   end

   // records whether the flag bit really left the device in this frame
   always_comb begin
      next_mark = mark;
      if (rise.cnt == 5'h00) begin
         next_mark.tag  = core.parity;
         next_mark.sent = 1'b0;
      end else if (rise.cnt == RISE_VERIFY && rise.addr_ok) begin
         next_mark.sent = 1'b1;
      end
   end

   always_ff @(posedge sck) begin
      mark <= next_mark;
   end

   // ==========================================================================
   // core side: select synchroniser, frame evaluation, write strobe
   always_comb begin
      logic       ss_rise;
      logic       ss_fall;
      logic       fresh;
      logic       sent_ok;
      logic       foreign;
      logic       invalid;
      logic [5:0] frame_len;
      logic [1:0] addr;
      logic [5:0] code;
      next_core          = core;
      next_core.ss_s1    = ss_n;
      next_core.ss_s2    = core.ss_s1;
      next_core.ss_s3    = core.ss_s2;
      next_core.rst_hold = 1'b0;
      next_core.wr.valid = 1'b0;
      ss_rise   = core.ss_s2 & ~core.ss_s3;
      ss_fall   = ~core.ss_s2 & core.ss_s3;
      // a frame with no falling edge leaves a stale count behind
      fresh     = (fall.tag == core.parity);
      frame_len = fresh ? fall.count : 6'h00;
      addr      = fall.addr;
      code      = fall.shift[CODE_POS +: 6];
      sent_ok   = mark.sent & (mark.tag == core.parity);
      foreign   = (frame_len >= ADDR_BITS) && (addr != OWN_ADDR);
      invalid   = (frame_len != FRAME_BITS) | ~hbs_code_used(code) |
                  core.overrun;

      // read values frozen while selected; at 2 Mbaud at most the data
      // byte is needed many core cycles after the freeze
      // relies on bit rate limit
      if (core.ss_s2) begin
         next_core.snap = rd_regs;
      end

      unique case (core.st)
         CORE_IDLE: begin
         end
         CORE_BUSY: begin
            if (core.proc_cnt == 4'h1) begin
               next_core.st = CORE_IDLE;
            end else begin
               next_core.proc_cnt = core.proc_cnt - 4'h1;
            end
         end
      endcase

      if (ss_fall) begin
         next_core.overrun = (core.st == CORE_BUSY);
      end

      if (ss_rise) begin
         next_core.overrun  = 1'b0;
         next_core.parity   = ~core.parity;
         next_core.st       = CORE_BUSY;
         next_core.proc_cnt = PROC_CNT;
         if (!foreign) begin
            if (sent_ok) begin
               next_core.err = 1'b0;
            end
            if (invalid) begin
               next_core.err = 1'b1;
            end
            if (!invalid && code == CODE_WR_CFG) begin
               next_core.wr = '{valid: 1'b1, target: WR_TGT_CFG,
                                data: fall.shift[7:0]};
            end
            if (!invalid && code == CODE_WR_STAT) begin
               next_core.wr = '{valid: 1'b1, target: WR_TGT_STAT,
                                data: fall.shift[7:0]};
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         core          <= '0;
         core.ss_s1    <= 1'b1;
         core.ss_s2    <= 1'b1;
         core.ss_s3    <= 1'b1;
         core.rst_hold <= 1'b1;
         core.st       <= CORE_IDLE;
      end else begin
         core <= next_core;
      end
   end

   // ==========================================================================
   // outputs
   assign so         = rise.so;
   assign so_oe      = rise.so_oe;
   assign wr_req     = core.wr;
   assign trans_fail = core.err;

endmodule : hbs_frame_ctrl

`default_nettype wire

// file: dv/hbs_frame_ctrl_props.sv
// port assertions for the serial frame control block
`timescale 1ns/1ps
`default_nettype none
module hbs_frame_ctrl_props (
   input wire logic                  ref_clk,
   input wire logic                  resetn,
   input wire logic                  sck,
   input wire logic                  ss_n,
   input wire logic                  si,
   input wire hbs_pkg::hbs_rd_regs_t rd_regs,
   input wire logic                  so,
   input wire logic                  so_oe,
   input wire hbs_pkg::hbs_wr_t      wr_req,
   input wire logic                  trans_fail
);
   import hbs_pkg::*;
   // ==========================================================================
   // link helpers: edge counts and address, cleared by a high select
   logic [4:0] rcnt;
   logic [3:0] fcnt;
   logic [1:0] addr;
   logic [7:0] ib;
   always_ff @(posedge sck or posedge ss_n) begin
      if (ss_n) rcnt <= 5'h00;
      else if (rcnt != 5'h1F) rcnt <= rcnt + 5'h01;
   end
   always_ff @(negedge sck or posedge ss_n) begin
      if (ss_n) begin
         fcnt <= 4'h0;
         addr <= 2'h0;
         ib   <= 8'h00;
      end else if (fcnt != 4'hF) begin
         fcnt <= fcnt + 4'h1;
         if (fcnt < 4'h2) addr <= {addr[0], si};
         if (fcnt < 4'h8) ib <= {ib[6:0], si};
      end
   end
   // ==========================================================================
   // sequences
   sequence s_verify;
      so ##1 !so ##1 so ##1 !so ##1 so ##1 (so == trans_fail);
   endsequence
   sequence s_zero_byte;
      !so [*8];
   endsequence
   sequence s_ones_byte;
      so [*8];
   endsequence
   // ==========================================================================
   // link domain
   a_addr_tristate: assert property (
      @(posedge sck) disable iff (ss_n) rcnt <= 5'h02 |-> !so_oe)
      else $error("output driven in address phase");
   a_own_drive: assert property (
      @(posedge sck) disable iff (ss_n)
      rcnt inside {[5'h03:5'h10]} && addr == OWN_ADDR |-> so_oe)
      else $error("own frame not driven");
   a_foreign_quiet: assert property (
      @(posedge sck) disable iff (ss_n)
      rcnt >= 5'h03 && addr != OWN_ADDR |-> !so_oe)
      else $error("foreign frame driven");
   a_verify_byte: assert property (
      @(posedge sck) disable iff (ss_n) rcnt == 5'h03 && so_oe |-> s_verify)
      else $error("verify byte wrong");
   // falling edges see all eight data bits; a 16 bit frame has no 17th rise
   a_write_zero: assert property (
      @(negedge sck) disable iff (ss_n)
      fcnt == 4'h8 && so_oe &&
      (ib[5:0] == CODE_WR_CFG || ib[5:0] == CODE_WR_STAT) |-> s_zero_byte)
      else $error("write reply not zero");
   a_unused_ones: assert property (
      @(negedge sck) disable iff (ss_n)
      fcnt == 4'h8 && so_oe && !hbs_code_used(ib[5:0]) |-> s_ones_byte)
      else $error("unused code reply not all ones");
   // ==========================================================================
   // core domain
   a_reset_quiet: assert property (
      @(posedge ref_clk) $past(!resetn) && !resetn
      |-> !so_oe && !wr_req.valid && !trans_fail)
      else $error("outputs active in reset");
   a_oe_deselect: assert property (
      @(posedge ref_clk) disable iff (!resetn) ss_n |-> !so_oe)
      else $error("output driven while deselected");
   a_write_idle: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      wr_req.valid |-> ss_n && $past(ss_n) ##1 !wr_req.valid)
      else $error("write strobe inside frame or long");
   a_flag_idle: assert property (
      @(posedge ref_clk) disable iff (!resetn) $changed(trans_fail) |-> ss_n)
      else $error("failure flag moved inside frame");
endmodule : hbs_frame_ctrl_props

bind hbs_frame_ctrl hbs_frame_ctrl_props u_props (.ref_clk(ref_clk),
   .resetn(resetn), .sck(sck), .ss_n(ss_n), .si(si), .rd_regs(rd_regs),
   .so(so), .so_oe(so_oe), .wr_req(wr_req), .trans_fail(trans_fail));
`default_nettype wire

// file: dv/hbs_master_model.sv
// serial master model for the link of the frame control block
`timescale 1ns/1ps
`default_nettype none
module hbs_master_model (
   output logic     sck,
   output logic     ss_n,
   output logic     si,
   input wire logic so_line
);
   initial begin
      sck  = 1'b0;
      ss_n = 1'b1;
      si   = 1'b0;
   end
   // ==========================================================================
   // frame of n bits after gap ns idle; clock idles low outside frames
   task automatic xfer(input logic [15:0] d, input int n, input int gap,
                       output logic [15:0] q);
      q = 16'hzzzz;
      #(gap);
      ss_n = 1'b0;
      #7.5;
      for (int i = 0; i < n; i++) begin
         // msb first, set before falling edge
         si  = (i < 16) ? d[15 - i] : 1'b0;
         sck = 1'b1;
         #7.5;
         if (i < 16) q[15 - i] = so_line;
         sck = 1'b0;
         #7.5;
      end
      ss_n = 1'b1;
      // line not held after release, so no stale bit is mistaken for data
      si = ~si;
   endtask : xfer
endmodule : hbs_master_model
`default_nettype wire

// file: dv/test_hbs_frame_ctrl.sv
// self-checking bench for the serial frame control block
`timescale 1ns/1ps
`default_nettype none
module test_hbs_frame_ctrl;
   import hbs_pkg::*;
   logic         ref_clk, resetn, sck, ss_n, si, so, so_oe, trans_fail;
   hbs_rd_regs_t rd_regs;
   hbs_wr_t      wr_req, wr_seen;
   wire          so_line;
   int           err_count, tests_run, cycles, wr_cnt;
   logic [15:0]  q;
   assign so_line = so_oe ? so : 1'bz;
   hbs_frame_ctrl DUT (.ref_clk(ref_clk), .resetn(resetn), .sck(sck),
      .ss_n(ss_n), .si(si), .rd_regs(rd_regs), .so(so), .so_oe(so_oe),
      .wr_req(wr_req), .trans_fail(trans_fail));
   hbs_master_model m (.sck(sck), .ss_n(ss_n), .si(si), .so_line(so_line));
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // ==========================================================================
   // write strobe capture and hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (wr_req.valid === 1'b1) begin
         wr_cnt++;
         wr_seen = wr_req;
      end
      if (cycles == 20000) begin
         err_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop;
      $display("mismatches %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [15:0] rep(input logic f, input logic [7:0] d);
      return {2'bzz, 5'b10101, f, d};
   endfunction : rep
   task automatic frame(input logic [15:0] d, input int n = 16,
                        input int gap = 200);
      m.xfer(d, n, gap, q);
      repeat (20) @(posedge ref_clk);
   endtask : frame
   // ==========================================================================
   // scenarios
   task automatic t_read;
      logic [5:0] rc [5] = '{CODE_RD_IDENT, CODE_RD_REV, CODE_RD_DIAG,
                             CODE_RD_CFG, CODE_RD_STAT};
      int         w;
      w = wr_cnt;
      for (int i = 0; i < 5; i++) begin
         frame({2'b00, rc[i], 8'hA5});
         chk(q, rep(1'b0, rd_regs[39 - 8 * i -: 8]));
      end
      chk(16'(wr_cnt - w), 16'h0000);
   endtask : t_read
   task automatic t_write;
      frame({2'b00, 6'h28, 8'h5A});
      chk(q, rep(1'b0, 8'h00));
      chk(16'(wr_seen), {6'h00, 1'b1, WR_TGT_CFG, 8'h5A});
      frame({2'b00, 6'h18, 8'hC3});
      chk(q, rep(1'b0, 8'h00));
      chk(16'(wr_seen), {6'h00, 1'b1, WR_TGT_STAT, 8'hC3});
   endtask : t_write
   task automatic t_unused;
      logic [5:0] uc [3] = '{6'h01, 6'h29, 6'h3F};
      for (int i = 0; i < 3; i++) begin
         frame({2'b00, uc[i], 8'h00});
         chk(q, rep(i != 0, 8'hFF));
         chk(16'(trans_fail), 16'h0001);
      end
      frame({2'b10, CODE_RD_IDENT, 8'h00});
      chk(q, 16'hzzzz);
      frame({2'b00, CODE_RD_REV, 8'h00});
      chk(q, rep(1'b1, rd_regs.revision));
      frame({2'b00, CODE_RD_REV, 8'h00});
      chk(q, rep(1'b0, rd_regs.revision));
   endtask : t_unused
   task automatic t_len;
      frame({2'b00, CODE_RD_DIAG, 8'h00}, 15);
      frame({2'b00, CODE_RD_DIAG, 8'h00}, 17);
      chk(q, rep(1'b1, rd_regs.diag));
      frame({2'b00, CODE_RD_DIAG, 8'h00});
      chk(q, rep(1'b1, rd_regs.diag));
      frame({2'b00, CODE_RD_DIAG, 8'h00});
      chk(q, rep(1'b0, rd_regs.diag));
      // a long foreign frame must not touch the flag
      frame({2'b10, CODE_RD_DIAG, 8'h00}, 17);
      chk(q, 16'hzzzz);
      frame({2'b00, CODE_RD_DIAG, 8'h00});
      chk(q, rep(1'b0, rd_regs.diag));
   endtask : t_len
   task automatic t_busy;
      int w;
      w = wr_cnt;
      m.xfer({2'b00, 6'h28, 8'h11}, 16, 200, q);
      // second frame lands while the first is still being processed
      frame({2'b00, 6'h28, 8'h22}, 16, 30);
      chk(16'(wr_cnt - w), 16'h0001);
      chk(16'(wr_seen), {6'h00, 1'b1, WR_TGT_CFG, 8'h11});
      frame({2'b00, CODE_RD_CFG, 8'h00});
      chk(q, rep(1'b1, rd_regs.cfg));
   endtask : t_busy
   task automatic t_reset;
      frame({2'b00, 6'h3F, 8'h00});
      chk(16'(trans_fail), 16'h0001);
      @(posedge ref_clk);
      resetn <= 1'b0;
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk(16'(trans_fail), 16'h0000);
      frame({2'b00, CODE_RD_STAT, 8'h00});
      chk(q, rep(1'b0, rd_regs.statcon));
   endtask : t_reset
   // ==========================================================================
   // main sequence
   initial begin
      resetn  <= 1'b0;
      rd_regs <= {8'hC3, 8'h5A, 8'h96, 8'h3C, 8'hE1};
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (8) @(posedge ref_clk);
      t_read();
      t_write();
      t_unused();
      t_len();
      t_busy();
      t_reset();
      report_and_stop();
   end
endmodule : test_hbs_frame_ctrl
`default_nettype wire
